// >>> design/dwi_dac_write.sv
// Two-wire slave write path and special command decoder of a multi-channel DAC.
`timescale 1ns/1ps

// Behaviour
// - Address, pointer, two data bytes, STOP update one addressed channel.
// - Slave address and pointer bytes are acknowledged by pulling the data line low.
// - Sixteen channels use four address bits; eight channels use the low three.
// - Without STOP the next byte is a new pointer followed by two data bytes.
// - The two register-select bits choose which channel register is written.
// - STOP at any point ends repeated-pointer or burst mode and idles the port.
// - Pointer 0xff starts burst mode at channel zero.
// - Burst advances the channel after each data pair, then reverts to pointer mode.
// - Toggle operation is not allowed during burst mode.
// - Register-select zero decodes the address bits as special commands.
// - Code 1100 writes control when direction is 0, selects it for reading when 1.
// - No-op changes no state and pulls busy low while processed.
// - Clear-code write stores fourteen data bits; the clear code resets to zero.
// - Clear pin or soft clear copies the clear code into every channel.
// - Soft clear holds busy low 20 us on sixteen, 15 us on eight channels.
// - Soft power-down idles all channels and keeps every register.
// - Soft power-up re-enables outputs, exit completes within 8 us.
// - Effective power-down is hardware input OR software power-down.
// - Soft reset returns registers to defaults and finishes within 135 us.
// - Slave address is 10101 followed by the two address-select pins.
module dwi_dac_write #(
	parameter int NUM_CHANNELS = 16
) (
	input  wire logic        clock,
	input  wire logic        arst_n,
	input  wire logic        scl_in,
	input  wire logic        sda_in,
	output logic             sda_out,
	output logic             sda_oe,
	input  wire logic        clear_input_n,
	input  wire logic        power_down_input,
	input  wire logic        address_select_pin_1,
	input  wire logic        address_select_pin_0,
	input  wire logic [7:0]  reg_addr,
	input  wire logic [31:0] reg_wdata,
	input  wire logic        reg_write,
	input  wire logic        reg_read,
	output logic [31:0]      reg_rdata,
	output logic             dac_wr_valid,
	output logic [3:0]       dac_wr_channel,
	output logic [1:0]       dac_wr_register,
	output logic [13:0]      dac_wr_data,
	output logic             clear_all,
	output logic             soft_reset,
	output logic [13:0]      clear_code,
	output logic [13:0]      control_value,
	output logic             control_write,
	output logic             control_read_select,
	output logic [5:0]       monitor_select,
	output logic             power_down,
	output logic             power_down_100k,
	output logic             toggle_allowed,
	output logic             busy_n
);
	import dwi_pkg::*;

	localparam logic [3:0] LAST_CHAN = 4'(NUM_CHANNELS - 1);
	localparam logic [11:0] CYC_SOFTWARE_CLEAR_COMMAND = (NUM_CHANNELS == 8) ? CYC_SOFT_CLR8 : CYC_SOFT_CLR16;

	generate
		if (NUM_CHANNELS != 8 && NUM_CHANNELS != 16) begin : g_bad_channels
			$error("NUM_CHANNELS must be 8 or 16");
		end
	endgenerate

	// ==========================================================================
	// Pin synchronisers and edge detection
	// ==========================================================================
	logic [5:0]       pin_s1_ff;
	logic [5:0]       pin_s2_ff;
	logic [2:0]       pin_s3_ff;
	logic             scl_s;
	logic             sda_s;
	logic             clr_n_s;
	logic             scl_rise;
	logic             scl_fall;
	logic             bus_start;
	logic             bus_stop;
	logic             clr_fall;

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			// Reset values match the idle pin levels, so no false edge or power-down follows reset.
			pin_s1_ff <= 6'h3b;
			pin_s2_ff <= 6'h3b;
			pin_s3_ff <= 3'h7;
		end else begin
			pin_s1_ff <= {scl_in, sda_in, clear_input_n, power_down_input,
				address_select_pin_1, address_select_pin_0};
			pin_s2_ff <= pin_s1_ff;
			pin_s3_ff <= pin_s2_ff[5:3];
		end
	end

	assign scl_s     = pin_s2_ff[5];
	assign sda_s     = pin_s2_ff[4];
	assign clr_n_s   = pin_s2_ff[3];
	assign scl_rise  = scl_s & ~pin_s3_ff[2];
	assign scl_fall  = ~scl_s & pin_s3_ff[2];
	assign bus_start = scl_s & pin_s3_ff[2] & pin_s3_ff[1] & ~sda_s;
	assign bus_stop  = scl_s & pin_s3_ff[2] & ~pin_s3_ff[1] & sda_s;
	assign clr_fall  = ~clr_n_s & pin_s3_ff[0];

	// ==========================================================================
	// Byte framing and acknowledge
	// ==========================================================================
	dwi_state_e       state_ff;
	logic [7:0]       shift_ff;
	logic [3:0]       bit_cnt_ff;
	logic             ack_phase_ff;
	logic             sda_oe_ff;
	logic             burst_ff;
	logic [3:0]       addr_ff;
	logic             rw_ff;
	logic [7:0]       data_hi_ff;
	logic             cmd_valid_ff;
	logic [15:0]      cmd_word_ff;
	logic [3:0]       cmd_addr_ff;
	logic             cmd_rw_ff;
	logic [1:0]       cfg_ff;
	logic             byte_done;
	logic             addr_match;

	assign byte_done  = scl_fall && bit_cnt_ff == 4'h8 && !ack_phase_ff;
	assign addr_match = shift_ff[7:1] == {SLAVE_ADDR_HI, pin_s2_ff[1:0]} && !shift_ff[0];

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			state_ff     <= ST_IDLE;
			shift_ff     <= 8'h00;
			bit_cnt_ff   <= 4'h0;
			ack_phase_ff <= 1'b0;
			sda_oe_ff    <= 1'b0;
			burst_ff     <= 1'b0;
			addr_ff      <= 4'h0;
			rw_ff        <= 1'b0;
			data_hi_ff   <= 8'h00;
			cmd_valid_ff <= 1'b0;
			cmd_word_ff  <= 16'h0000;
			cmd_addr_ff  <= 4'h0;
			cmd_rw_ff    <= 1'b0;
		end else begin
			cmd_valid_ff <= 1'b0;
			if (bus_stop || !cfg_ff[CFG_ENABLE]) begin
				state_ff     <= ST_IDLE;
				burst_ff     <= 1'b0;
				bit_cnt_ff   <= 4'h0;
				ack_phase_ff <= 1'b0;
				sda_oe_ff    <= 1'b0;
			end else if (bus_start) begin
				state_ff     <= ST_ADDR;
				burst_ff     <= 1'b0;
				bit_cnt_ff   <= 4'h0;
				ack_phase_ff <= 1'b0;
				sda_oe_ff    <= 1'b0;
			end else if (scl_rise && bit_cnt_ff < 4'h8) begin
				shift_ff   <= {shift_ff[6:0], sda_s};
				bit_cnt_ff <= bit_cnt_ff + 4'h1;
			end else if (scl_fall && ack_phase_ff) begin
				ack_phase_ff <= 1'b0;
				sda_oe_ff    <= 1'b0;
				bit_cnt_ff   <= 4'h0;
			end else if (byte_done) begin
				ack_phase_ff <= 1'b1;
				case (state_ff)
					ST_ADDR: begin
						state_ff  <= addr_match ? ST_PTR : ST_SKIP;
						sda_oe_ff <= addr_match;
					end
					ST_PTR: begin
						sda_oe_ff <= 1'b1;
						state_ff  <= ST_DHI;
						if (shift_ff == BURST_PTR) begin
							burst_ff <= 1'b1;
							addr_ff  <= 4'h0;
							rw_ff    <= 1'b0;
						end else begin
							addr_ff <= shift_ff[3:0];
							rw_ff   <= shift_ff[PTR_RW_BIT];
						end
					end
					ST_DHI: begin
						sda_oe_ff  <= 1'b1;
						data_hi_ff <= shift_ff;
						state_ff   <= ST_DLO;
					end
					ST_DLO: begin
						sda_oe_ff    <= 1'b1;
						cmd_valid_ff <= 1'b1;
						cmd_word_ff  <= {data_hi_ff, shift_ff};
						cmd_addr_ff  <= addr_ff;
						cmd_rw_ff    <= rw_ff;
						if (burst_ff && addr_ff != LAST_CHAN) begin
							addr_ff  <= addr_ff + 4'h1;
							state_ff <= ST_DHI;
						end else begin
							burst_ff <= 1'b0;
							state_ff <= ST_PTR;
						end
					end
					default: begin
						state_ff <= state_ff;
					end
				endcase
			end
		end
	end

	// ==========================================================================
	// Command decode
	// ==========================================================================
	logic             is_sfr;
	logic             do_nop;
	logic             do_software_clear_command;
	logic             do_pwr_up;
	logic             do_reset;
	logic             do_clr_code;
	logic [13:0]      clear_code_ff;
	logic [13:0]      control_ff;
	logic             control_write_ff;
	logic             control_rd_ff;
	logic [5:0]       monitor_ff;
	logic             soft_pd_ff;
	logic             clear_all_ff;
	logic             soft_reset_ff;

	assign is_sfr      = cmd_valid_ff && cmd_word_ff[REG_SEL_HI:REG_SEL_LO] == 2'b00;
	assign do_nop      = is_sfr && cmd_addr_ff == SFR_NOP;
	assign do_software_clear_command = is_sfr && cmd_addr_ff == SFR_SOFTWARE_CLEAR_COMMAND && !cmd_rw_ff;
	assign do_pwr_up   = is_sfr && cmd_addr_ff == SFR_PWR_UP && !cmd_rw_ff;
	assign do_reset    = is_sfr && cmd_addr_ff == SFR_RESET && !cmd_rw_ff;
	assign do_clr_code = is_sfr && cmd_addr_ff == SFR_CLR_CODE && !cmd_rw_ff;

	logic             dac_wr_valid_ff;
	logic [3:0]       dac_wr_channel_ff;
	logic [1:0]       dac_wr_register_ff;
	logic [13:0]      dac_wr_data_ff;

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			dac_wr_valid_ff    <= 1'b0;
			dac_wr_channel_ff  <= 4'h0;
			dac_wr_register_ff <= 2'h0;
			dac_wr_data_ff     <= 14'h0000;
		end else begin
			dac_wr_valid_ff <= cmd_valid_ff && !is_sfr;
			if (cmd_valid_ff && !is_sfr) begin
				dac_wr_channel_ff  <= (NUM_CHANNELS == 8) ? {1'b0, cmd_addr_ff[2:0]} : cmd_addr_ff;
				dac_wr_register_ff <= cmd_word_ff[REG_SEL_HI:REG_SEL_LO];
				dac_wr_data_ff     <= cmd_word_ff[13:0];
			end
		end
	end

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			clear_code_ff    <= CLR_CODE_RESET;
			control_ff       <= CONTROL_RESET;
			control_write_ff <= 1'b0;
			control_rd_ff    <= 1'b0;
			monitor_ff       <= MONITOR_RESET;
			soft_pd_ff       <= 1'b0;
			clear_all_ff     <= 1'b0;
			soft_reset_ff    <= 1'b0;
		end else begin
			clear_all_ff     <= do_software_clear_command || clr_fall;
			soft_reset_ff    <= do_reset;
			control_write_ff <= is_sfr && cmd_addr_ff == SFR_CONTROL && !cmd_rw_ff;
			if (do_reset) begin
				clear_code_ff <= CLR_CODE_RESET;
				control_ff    <= CONTROL_RESET;
				control_rd_ff <= 1'b0;
				monitor_ff    <= MONITOR_RESET;
				soft_pd_ff    <= 1'b0;
			end else if (do_clr_code) begin
				clear_code_ff <= cmd_word_ff[13:0];
			end else if (is_sfr && cmd_addr_ff == SFR_CONTROL) begin
				if (cmd_rw_ff) begin
					control_rd_ff <= 1'b1;
				end else begin
					control_ff    <= cmd_word_ff[13:0];
					control_rd_ff <= 1'b0;
				end
			end else if (is_sfr && cmd_addr_ff == SFR_MONITOR && !cmd_rw_ff) begin
				monitor_ff <= cmd_word_ff[13:MON_SEL_LSB];
			end else if (is_sfr && cmd_addr_ff == SFR_PWR_DOWN && !cmd_rw_ff) begin
				soft_pd_ff <= 1'b1;
			end else if (do_pwr_up) begin
				soft_pd_ff <= 1'b0;
			end
		end
	end

	// ==========================================================================
	// Busy timing
	// ==========================================================================
	logic [BUSY_W-1:0] busy_cnt_ff;
	logic [BUSY_W-1:0] busy_load;
	logic [BUSY_W-1:0] nxt_busy_cnt;
	logic              busy_n_ff;

	always_comb begin
		busy_load = '0;
		if (do_reset) begin
			busy_load = CYC_SOFT_RESET;
		end else if (do_software_clear_command || clr_fall) begin
			busy_load = CYC_SOFTWARE_CLEAR_COMMAND;
		end else if (do_pwr_up) begin
			busy_load = CYC_POWER_UP;
		end else if (do_nop) begin
			busy_load = CYC_NOP;
		end
		if (busy_load > busy_cnt_ff) begin
			nxt_busy_cnt = busy_load;
		end else if (busy_cnt_ff != '0) begin
			nxt_busy_cnt = busy_cnt_ff - 12'h001;
		end else begin
			nxt_busy_cnt = '0;
		end
	end

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			busy_cnt_ff <= '0;
			busy_n_ff   <= 1'b1;
		end else begin
			busy_cnt_ff <= nxt_busy_cnt;
			busy_n_ff   <= nxt_busy_cnt == '0;
		end
	end

	// ==========================================================================
	// Power and mode status
	// ==========================================================================
	logic             power_down_ff;
	logic             toggle_allowed_ff;

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			power_down_ff     <= 1'b0;
			toggle_allowed_ff <= 1'b1;
		end else begin
			power_down_ff     <= pin_s2_ff[2] | soft_pd_ff;
			toggle_allowed_ff <= !burst_ff;
		end
	end

	// ==========================================================================
	// Software register port
	// ==========================================================================
	logic [31:0]      reg_rdata_ff;

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			cfg_ff       <= CONFIG_RESET;
			reg_rdata_ff <= 32'h0000_0000;
		end else begin
			if (reg_write && reg_addr == REG_CONFIG) begin
				cfg_ff <= reg_wdata[1:0];
			end
			reg_rdata_ff <= 32'h0000_0000;
			if (reg_read) begin
				if (reg_addr == REG_STATUS) begin
					reg_rdata_ff <= {22'h0, state_ff, burst_ff, soft_pd_ff, power_down_ff, ~busy_n_ff};
				end else if (reg_addr == REG_CLR_CODE) begin
					reg_rdata_ff <= {18'h0, clear_code_ff};
				end else if (reg_addr == REG_CONTROL) begin
					reg_rdata_ff <= {17'h0, control_rd_ff, control_ff};
				end else if (reg_addr == REG_MONITOR) begin
					reg_rdata_ff <= {26'h0, monitor_ff};
				end else if (reg_addr == REG_CONFIG) begin
					reg_rdata_ff <= {30'h0, cfg_ff};
				end
			end
		end
	end

	assign sda_out             = 1'b0;
	assign sda_oe              = sda_oe_ff;
	assign reg_rdata           = reg_rdata_ff;
	assign dac_wr_valid        = dac_wr_valid_ff;
	assign dac_wr_channel      = dac_wr_channel_ff;
	assign dac_wr_register     = dac_wr_register_ff;
	assign dac_wr_data         = dac_wr_data_ff;
	assign clear_all           = clear_all_ff;
	assign soft_reset          = soft_reset_ff;
	assign clear_code          = clear_code_ff;
	assign control_value       = control_ff;
	assign control_write       = control_write_ff;
	assign control_read_select = control_rd_ff;
	assign monitor_select      = monitor_ff;
	assign power_down          = power_down_ff;
	assign power_down_100k     = cfg_ff[CFG_PD_100K];
	assign toggle_allowed      = toggle_allowed_ff;
	assign busy_n              = busy_n_ff;

	// ==========================================================================
	// Assertions
	// ==========================================================================
	default clocking cb @(posedge clock); endclocking
	default disable iff (!arst_n);

	property p_addr_ack;
		byte_done && state_ff == ST_ADDR && addr_match |=> sda_oe_ff && state_ff == ST_PTR;
	endproperty
	a_addr_ack: assert property (p_addr_ack) else $error("address not acknowledged");

	property p_stop_idle;
		bus_stop |=> state_ff == ST_IDLE && !burst_ff && !sda_oe_ff;
	endproperty
	a_stop_idle: assert property (p_stop_idle) else $error("stop did not idle the port");

	property p_burst_start;
		byte_done && state_ff == ST_PTR && shift_ff == BURST_PTR |=> burst_ff && addr_ff == 4'h0;
	endproperty
	a_burst_start: assert property (p_burst_start) else $error("burst did not start at channel zero");

	property p_chan_write;
		cmd_valid_ff && !is_sfr |=> dac_wr_valid_ff && dac_wr_register_ff == $past(cmd_word_ff[15:14])
			&& dac_wr_data_ff == $past(cmd_word_ff[13:0]);
	endproperty
	a_chan_write: assert property (p_chan_write) else $error("channel write mismatch");

	property p_nop_busy;
		do_nop && busy_cnt_ff == '0 |=> !busy_n_ff ##1 busy_n_ff;
	endproperty
	a_nop_busy: assert property (p_nop_busy) else $error("no-op busy pulse wrong");

	property p_clr_code;
		do_clr_code |=> clear_code == $past(cmd_word_ff[13:0]);
	endproperty
	a_clr_code: assert property (p_clr_code) else $error("clear code not stored");

	property p_software_clear_command;
		do_software_clear_command |=> clear_all_ff ##0 !busy_n_ff [*8];
	endproperty
	a_software_clear_command: assert property (p_software_clear_command) else $error("soft clear not carried out");

	property p_pd_or;
		soft_pd_ff |=> power_down_ff;
	endproperty
	a_pd_or: assert property (p_pd_or) else $error("power-down not combined");

	property p_reset;
		do_reset |=> soft_reset_ff && clear_code_ff == CLR_CODE_RESET && !soft_pd_ff;
	endproperty
	a_reset: assert property (p_reset) else $error("soft reset did not restore defaults");

	property p_toggle;
		burst_ff |=> !toggle_allowed_ff;
	endproperty
	a_toggle: assert property (p_toggle) else $error("toggle allowed during burst");

endmodule : dwi_dac_write

// >>> design/dwi_pkg.sv
// Constants shared by the DAC two-wire write path and command decoder.
package dwi_pkg;

	// ==========================================================================
	// Timing
	// ==========================================================================
	localparam int          CLK_PERIOD_NS   = 40;
	localparam int          T_SOFT_CLR16_NS = 20000;
	localparam int          T_SOFT_CLR8_NS  = 15000;
	localparam int          T_POWER_UP_NS   = 8000;
	localparam int          T_SOFT_RESET_NS = 135000;
	localparam int          BUSY_W          = 12;
	localparam logic [11:0] CYC_SOFT_CLR16  = 12'(T_SOFT_CLR16_NS / CLK_PERIOD_NS);
	localparam logic [11:0] CYC_SOFT_CLR8   = 12'(T_SOFT_CLR8_NS / CLK_PERIOD_NS);
	localparam logic [11:0] CYC_POWER_UP    = 12'(T_POWER_UP_NS / CLK_PERIOD_NS);
	localparam logic [11:0] CYC_SOFT_RESET  = 12'(T_SOFT_RESET_NS / CLK_PERIOD_NS);
	localparam logic [11:0] CYC_NOP         = 12'h001;

	// ==========================================================================
	// Link framing
	// ==========================================================================
	localparam logic [4:0] SLAVE_ADDR_HI = 5'h15;
	localparam logic [7:0] BURST_PTR     = 8'hff;
	localparam int         PTR_RW_BIT    = 5;
	localparam int         REG_SEL_HI    = 15;
	localparam int         REG_SEL_LO    = 14;
	localparam int         MON_SEL_LSB   = 8;

	// ==========================================================================
	// Special command codes on the channel address bits
	// ==========================================================================
	localparam logic [3:0] SFR_NOP      = 4'h0;
	localparam logic [3:0] SFR_CLR_CODE = 4'h1;
	localparam logic [3:0] SFR_SOFTWARE_CLEAR_COMMAND = 4'h2;
	localparam logic [3:0] SFR_PWR_DOWN = 4'h8;
	localparam logic [3:0] SFR_PWR_UP   = 4'h9;
	localparam logic [3:0] SFR_MONITOR  = 4'ha;
	localparam logic [3:0] SFR_CONTROL  = 4'hc;
	localparam logic [3:0] SFR_RESET    = 4'hf;

	// ==========================================================================
	// Software registers and reset values
	// ==========================================================================
	localparam logic [7:0]  REG_STATUS     = 8'h00;
	localparam logic [7:0]  REG_CLR_CODE   = 8'h04;
	localparam logic [7:0]  REG_CONTROL    = 8'h08;
	localparam logic [7:0]  REG_MONITOR    = 8'h0c;
	localparam logic [7:0]  REG_CONFIG     = 8'h10;
	localparam int          CFG_ENABLE     = 0;
	localparam int          CFG_PD_100K    = 1;
	localparam logic [1:0]  CONFIG_RESET   = 2'h1;
	localparam logic [13:0] CLR_CODE_RESET = 14'h0000;
	localparam logic [13:0] CONTROL_RESET  = 14'h0000;
	localparam logic [5:0]  MONITOR_RESET  = 6'h3f;

	typedef enum logic [5:0] {
		ST_IDLE = 6'h01,
		ST_ADDR = 6'h02,
		ST_PTR  = 6'h04,
		ST_DHI  = 6'h08,
		ST_DLO  = 6'h10,
		ST_SKIP = 6'h20
	} dwi_state_e;

endpackage : dwi_pkg

// >>> testbench/dwi_i2c_master.sv
// Two-wire bus master model that drives the link clock and pulls the data line.
`timescale 1ns/1ps
module dwi_i2c_master (
	input  wire logic clock,
	input  wire logic sda,
	output logic      scl,
	output logic      sda_low
);
	// The clock idles high and stands still between frames; a released data line floats high on its pull-up.
	initial begin
		scl = 1'b1;
		sda_low = 1'b0;
	end
	task automatic w(input int n);
		repeat (n) @(posedge clock);
	endtask : w
	// From a low clock, release the data line and raise the clock first, so this also makes a repeated start.
	task automatic start();
		sda_low <= 1'b0;
		w(2);
		scl <= 1'b1;
		w(4);
		sda_low <= 1'b1;
		w(4);
		scl <= 1'b0;
		w(2);
	endtask : start
	task automatic stop();
		sda_low <= 1'b1;
		w(2);
		scl <= 1'b1;
		w(4);
		sda_low <= 1'b0;
		w(4);
	endtask : stop
	task automatic send(input logic [7:0] b, output logic ack);
		for (int i = 7; i >= 0; i--) begin
			sda_low <= ~b[i];
			w(2);
			scl <= 1'b1;
			w(4);
			scl <= 1'b0;
			w(2);
		end
		sda_low <= 1'b0;
		w(2);
		scl <= 1'b1;
		w(2);
		ack = sda;
		w(2);
		scl <= 1'b0;
		w(2);
	endtask : send
endmodule : dwi_i2c_master

// >>> testbench/dac_i2c_write_and_sfr_decoder_tb.sv
// Self-checking bench for the two-wire DAC write path and command decoder.
`timescale 1ns/1ps
module dac_i2c_write_and_sfr_decoder_tb;
	import dwi_pkg::*;
	localparam logic [7:0] ADDR_W = {SLAVE_ADDR_HI, 2'b10, 1'b0};
	logic        clock = 1'b0, arst_n = 1'b0, clear_n = 1'b1, pd_in = 1'b0, rw = 1'b0, rr = 1'b0;
	logic        scl, sda_low, ack, oe, so, wv, clear_pulse, srst, pd, pd100k, tog, busy_n, ctl_wr, ctl_rs;
	logic [1:0]  ad = 2'b10;
	logic [7:0]  ra = 8'h00;
	logic [31:0] wd = 32'h0, rd;
	logic [3:0]  wch;
	logic [1:0]  wreg;
	logic [13:0] wdat, ccode, cval;
	logic [5:0]  mon;
	int          num_errors = 0, tests_run = 0, n_wr, n_clear, n_busy, n_srst, n_ctl;
	wire         sda = ~(sda_low | (oe & ~so));

	always #20 clock = ~clock;

	dwi_i2c_master m (.clock(clock), .sda(sda), .scl(scl), .sda_low(sda_low));
	dwi_dac_write #(.NUM_CHANNELS(16)) dut (
		.clock(clock),
		.arst_n(arst_n),
		.scl_in(scl),
		.sda_in(sda),
		.sda_out(so),
		.sda_oe(oe),
		.clear_input_n(clear_n),
		.power_down_input(pd_in),
		.address_select_pin_1(ad[1]),
		.address_select_pin_0(ad[0]),
		.reg_addr(ra),
		.reg_wdata(wd),
		.reg_write(rw),
		.reg_read(rr),
		.reg_rdata(rd),
		.dac_wr_valid(wv),
		.dac_wr_channel(wch),
		.dac_wr_register(wreg),
		.dac_wr_data(wdat),
		.clear_all(clear_pulse),
		.soft_reset(srst),
		.clear_code(ccode),
		.control_value(cval),
		.control_write(ctl_wr),
		.control_read_select(ctl_rs),
		.monitor_select(mon),
		.power_down(pd),
		.power_down_100k(pd100k),
		.toggle_allowed(tog),
		.busy_n(busy_n)
	);

	// ==========================================================================
	// Event counters and shared tasks
	// ==========================================================================
	always @(posedge clock) begin
		n_wr += (wv === 1'b1);
		n_clear += (clear_pulse === 1'b1);
		n_busy += (busy_n === 1'b0);
		n_srst += (srst === 1'b1);
		n_ctl += (ctl_wr === 1'b1);
	end
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		tests_run++;
		if (g !== e) begin
			num_errors++;
			$display("BAD %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] e);
		@(posedge clock);
		rr <= 1'b1;
		ra <= a;
		@(posedge clock);
		rr <= 1'b0;
		#1 chk(nm, e, rd);
	endtask : rchk
	task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
		@(posedge clock);
		rw <= 1'b1;
		ra <= a;
		wd <= d;
		@(posedge clock);
		rw <= 1'b0;
		@(posedge clock);
	endtask : wr_reg
	task automatic sb(input logic [7:0] b, input logic e);
		m.send(b, ack);
		chk("ack", e, ack);
	endtask : sb
	task automatic frame(input logic [7:0] p, input logic [15:0] d, input bit s);
		m.start();
		sb(ADDR_W, 1'b0);
		sb(p, 1'b0);
		sb(d[15:8], 1'b0);
		sb(d[7:0], 1'b0);
		if (s)
			m.stop();
	endtask : frame

	// ==========================================================================
	// Scenarios
	// ==========================================================================
	task automatic t_reset();
		rchk("clear_code", REG_CLR_CODE, 32'h0);
		rchk("monitor", REG_MONITOR, 32'h3f);
		rchk("config", REG_CONFIG, 32'h1);
		rchk("unmapped", 8'h44, 32'h0);
		chk("busy_n", 1, busy_n);
		chk("toggle", 1, tog);
	endtask : t_reset
	task automatic t_writes();
		n_wr = 0;
		frame(8'h05, {2'b11, 14'h1234}, 1'b0);
		chk("wr", 1, n_wr);
		chk("chan", 5, wch);
		chk("regsel", 3, wreg);
		chk("data", 14'h1234, wdat);
		sb(8'h0e, 1'b0);
		sb(8'h95, 1'b0);
		sb(8'h55, 1'b0);
		m.stop();
		chk("chan", 14, wch);
		chk("regsel", 2, wreg);
		chk("data", 14'h1555, wdat);
		rchk("status", REG_STATUS, {22'h0, 6'h01, 4'h0});
	endtask : t_writes
	task automatic t_burst();
		m.start();
		sb(ADDR_W, 1'b0);
		sb(BURST_PTR, 1'b0);
		for (int i = 0; i < 16; i++) begin
			sb(8'h40, 1'b0);
			sb(8'(i + 8'h30), 1'b0);
			chk("chan", i, wch);
			chk("data", i + 8'h30, wdat);
			chk("toggle", i == 15, tog);
		end
		frame(8'h07, {2'b10, 14'h0777}, 1'b1);
		chk("chan", 7, wch);
		chk("toggle", 1, tog);
	endtask : t_burst
	task automatic t_refuse();
		n_wr = 0;
		m.start();
		sb({SLAVE_ADDR_HI, 2'b01, 1'b0}, 1'b1);
		sb(8'h05, 1'b1);
		m.stop();
		m.start();
		sb({SLAVE_ADDR_HI, 2'b10, 1'b1}, 1'b1);
		m.stop();
		ad <= 2'b01;
		m.start();
		sb({SLAVE_ADDR_HI, 2'b01, 1'b0}, 1'b0);
		m.stop();
		ad <= 2'b10;
		wr_reg(REG_CONFIG, 32'h0);
		m.start();
		sb(ADDR_W, 1'b1);
		m.stop();
		wr_reg(REG_CONFIG, 32'h1);
		chk("wr", 0, n_wr);
	endtask : t_refuse
	task automatic t_cmds();
		n_wr = 0;
		frame(SFR_CLR_CODE, 16'h2abc, 1'b1);
		rchk("clear_code", REG_CLR_CODE, 32'h2abc);
		n_busy = 0;
		frame(SFR_NOP, 16'h0, 1'b1);
		m.w(20);
		chk("busy", CYC_NOP, n_busy);
		chk("clear_code", 14'h2abc, ccode);
		{n_busy, n_clear} = 0;
		frame(SFR_SOFTWARE_CLEAR_COMMAND, 16'h0, 1'b1);
		m.w(600);
		chk("clear", 1, n_clear);
		chk("busy", CYC_SOFT_CLR16, n_busy);
		frame(SFR_PWR_DOWN, 16'h0, 1'b1);
		chk("pd", 1, pd);
		chk("clear_code", 14'h2abc, ccode);
		n_busy = 0;
		frame(SFR_PWR_UP, 16'h0, 1'b1);
		m.w(300);
		chk("pd", 0, pd);
		chk("busy", CYC_POWER_UP, n_busy);
		pd_in <= 1'b1;
		m.w(5);
		chk("pd", 1, pd);
		pd_in <= 1'b0;
		wr_reg(REG_CONFIG, 32'h3);
		chk("pd100k", 1, pd100k);
		wr_reg(REG_CONFIG, 32'h1);
		chk("pd", 0, pd);
		frame(SFR_MONITOR, {2'b00, 6'h05, 8'h00}, 1'b1);
		chk("monitor", 5, mon);
		n_ctl = 0;
		frame(SFR_CONTROL, 16'h1111, 1'b1);
		chk("ctl", 14'h1111, cval);
		chk("ctl_wr", 1, n_ctl);
		frame(8'h20 | SFR_CONTROL, 16'h0, 1'b1);
		chk("ctl_rs", 1, ctl_rs);
		chk("ctl_wr", 1, n_ctl);
		{n_srst, n_busy} = 0;
		frame(SFR_RESET, 16'h0, 1'b1);
		m.w(3500);
		chk("srst", 1, n_srst);
		chk("busy", CYC_SOFT_RESET, n_busy);
		chk("clear_code", 0, ccode);
		chk("monitor", 6'h3f, mon);
		chk("wr", 0, n_wr);
		n_clear = 0;
		clear_n <= 1'b0;
		m.w(10);
		clear_n <= 1'b1;
		m.w(600);
		chk("clear", 1, n_clear);
	endtask : t_cmds

	task automatic close_out();
		$display("checks %0d errors %0d", tests_run, num_errors);
		if (num_errors == 0 && tests_run > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : close_out

	initial begin
		m.w(2);
		arst_n <= 1'b1;
		m.w(4);
		t_reset();
		t_writes();
		t_burst();
		t_refuse();
		t_cmds();
		close_out();
	end
	initial begin
		#2000000;
		num_errors++;
		close_out();
	end
endmodule : dac_i2c_write_and_sfr_decoder_tb
